// ---- verilog/hcsc_cfg.svh ----
// register offsets, field positions, reset values and timing counts for the hub status/command bank
`ifndef HCSC_CFG_SVH
`define HCSC_CFG_SVH
`define HCSC_ADDR_W 8
`define HCSC_STATUS_CMD_OFFSET 8'hF8
`define HCSC_STATUS_CMD_RESET 8'h00
`define HCSC_BIT_CONFIG_MODE 0
`define HCSC_BIT_RELOAD_CMD 1
`define HCSC_RELOAD_TIME_NS 200
`define HCSC_CLK_PERIOD_NS 40
`define HCSC_RELOAD_CYCLES ((`HCSC_RELOAD_TIME_NS + `HCSC_CLK_PERIOD_NS - 1) / `HCSC_CLK_PERIOD_NS)
`define HCSC_CFG_RESET 8'h00
// strap synchroniser idle image: power straps high, polarity high, charge straps low
`define HCSC_STRAP_SYNC_RESET 8'hE0
`endif

// ---- verilog/hcsc_pkg.sv ----
// types shared by the hub status/command bank
package hcsc_pkg;
  typedef logic [7:0] hcsc_byte_t;
  typedef enum logic [1:0] {
    HCSC_IDLE = 2'b00,
    HCSC_RELOAD = 2'b01,
    HCSC_DONE = 2'b11
  } hcsc_state_t;
endpackage

// ---- verilog/hcsc_status_cmd.sv ----
// hub device status/command register with straps, config store and upstream attach gate
`timescale 1ns/1ps
`include "hcsc_cfg.svh"
//Contract
// - status bits 7:2 ignore writes and read as zero
// - writing one to reload bit restores all config registers to reset values
// - reload bit self-clears when restore ends; writing zero changes nothing
// - config mode flag set by hardware on entering management mode
// - upstream attach held off while config mode flag is one
// - writing one clears config mode flag; writing zero has no effect
// - both power straps low gives individual per-port power control
// - each port's charge strap high enables battery charge support
// - polarity strap unconnected or high drives power enables active high
module hcsc_status_cmd (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // management register port
  input wire logic mgmt_mode_enter_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [`HCSC_ADDR_W-1:0] reg_addr_in,
  input wire hcsc_pkg::hcsc_byte_t reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // straps
  input wire logic ganged_n_in,
  input wire logic port_power_mgmt_n_in,
  input wire logic power_enable_polarity_in,
  input wire logic [3:0] charge_enable_port_in,
  // port power requests from hub core
  input wire logic [3:0] port_power_request_in,
  // outputs
  output logic upstream_attach_allow_out,
  output logic individual_power_out,
  output logic [3:0] charge_enable_out,
  output logic [3:0] port_power_enable_out,
  output logic reload_busy_out
);
  import hcsc_pkg::*;

  // synchronisers for pins
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [3:0] req_meta;
  logic [3:0] req_sync;
  logic mode_meta;
  logic mode_sync;
  logic mode_prev;

  // register state
  logic config_mode_flag;
  logic register_reload_cmd;
  hcsc_state_t state;
  hcsc_state_t next_state;
  logic [3:0] reload_count;
  hcsc_byte_t cfg_mem [0:7];
  logic next_config_mode_flag;
  logic next_register_reload_cmd;
  logic [7:0] next_rdata;
  logic polarity_high;
  logic hit_status;
  logic hit_cfg;
  logic reload_done;
  logic mode_rise;

  // named strobes and selections
  logic status_write;
  logic reload_request;
  logic flag_clear_request;
  logic reload_active;
  logic cfg_write_allowed;
  logic next_individual_power;
  logic [3:0] next_port_power;

  // two-flop sampling of straps and mode line
  // only the second flop of each pair is read by logic
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // straps start at their idle levels so no port is powered or reported
      // individually switched in the two cycles before the first real sample
      pin_meta <= `HCSC_STRAP_SYNC_RESET;
      pin_sync <= `HCSC_STRAP_SYNC_RESET;
      req_meta <= 4'h0;
      req_sync <= 4'h0;
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
      mode_prev <= 1'b0;
    end else begin
      pin_meta <= {ganged_n_in, port_power_mgmt_n_in, power_enable_polarity_in, 1'b0, charge_enable_port_in};
      pin_sync <= pin_meta;
      req_meta <= port_power_request_in;
      req_sync <= req_meta;
      mode_meta <= mgmt_mode_enter_in;
      mode_sync <= mode_meta;
      mode_prev <= mode_sync;
    end
  end

  // slot decode of the config store, shared by all eight slots below
  function automatic logic cfg_slot_hit(input logic [`HCSC_ADDR_W-1:0] addr, input logic [2:0] slot);
    cfg_slot_hit = (addr[7:3] == 5'h00) && (addr[2:0] == slot);
  endfunction

  // address decode
  // status byte sits at its fixed offset, the store fills the bottom eight bytes
  assign hit_status = (reg_addr_in == `HCSC_STATUS_CMD_OFFSET);
  assign hit_cfg = (reg_addr_in[7:3] == 5'h00);
  assign mode_rise = mode_sync & ~mode_prev;
  assign reload_done = (state == HCSC_DONE);
  assign reload_active = (state == HCSC_RELOAD);
  // an unconnected polarity strap floats high through the pad pull-up
  assign polarity_high = pin_sync[5];

  // write strobes split by target; config writes are dropped while the reload bit is set
  assign status_write = reg_write_in && hit_status;
  assign reload_request = status_write && reg_wdata_in[`HCSC_BIT_RELOAD_CMD];
  assign flag_clear_request = status_write && reg_wdata_in[`HCSC_BIT_CONFIG_MODE];
  assign cfg_write_allowed = reg_write_in && hit_cfg && !register_reload_cmd;

  // power selections, registered with the other outputs
  assign next_individual_power = ~pin_sync[7] & ~pin_sync[6];
  assign next_port_power = polarity_high ? req_sync : ~req_sync;

  // reload sequencer: one idle cycle, the restore cycles, then a done cycle
  // that drops the reload bit; the store is held at reset through the restore
  always_comb begin
    next_state = state;
    case (state)
      HCSC_IDLE: begin
        if (register_reload_cmd) begin
          next_state = HCSC_RELOAD;
        end
      end
      HCSC_RELOAD: begin
        if (reload_count == 4'(`HCSC_RELOAD_CYCLES - 1)) begin
          next_state = HCSC_DONE;
        end
      end
      default: begin
        next_state = HCSC_IDLE;
      end
    endcase
  end

  // flag updates, set wins over clear
  // a reload write in the done cycle keeps the bit set and starts again
  always_comb begin
    next_config_mode_flag = config_mode_flag;
    if (flag_clear_request) begin
      next_config_mode_flag = 1'b0;
    end
    if (mode_rise) begin
      next_config_mode_flag = 1'b1;
    end
    next_register_reload_cmd = register_reload_cmd;
    if (reload_done) begin
      next_register_reload_cmd = 1'b0;
    end
    if (reload_request) begin
      next_register_reload_cmd = 1'b1;
    end
  end

  // read data mux; unmapped addresses read as zero
  // the status byte shows only its two live bits
  always_comb begin
    next_rdata = 8'h00;
    if (hit_status) begin
      next_rdata = {6'h00, register_reload_cmd, config_mode_flag};
    end else if (hit_cfg) begin
      next_rdata = cfg_mem[reg_addr_in[2:0]];
    end
  end

  // status register, sequencer and outputs
  // every output is a flop so nothing combinational reaches the pins
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_mode_flag <= 1'b0;
      register_reload_cmd <= 1'b0;
      state <= HCSC_IDLE;
      reload_count <= 4'h0;
      reg_rdata_out <= 8'h00;
      upstream_attach_allow_out <= 1'b0;
      individual_power_out <= 1'b0;
      charge_enable_out <= 4'h0;
      port_power_enable_out <= 4'h0;
      reload_busy_out <= 1'b0;
    end else begin
      config_mode_flag <= next_config_mode_flag;
      register_reload_cmd <= next_register_reload_cmd;
      state <= next_state;
      reload_count <= reload_active ? reload_count + 4'h1 : 4'h0;
      if (reg_read_in) begin
        reg_rdata_out <= next_rdata;
      end
      upstream_attach_allow_out <= ~config_mode_flag;
      individual_power_out <= next_individual_power;
      charge_enable_out <= pin_sync[3:0];
      port_power_enable_out <= next_port_power;
      reload_busy_out <= register_reload_cmd;
    end
  end

  // general configuration store, restored by reload
  // the restore outranks a host write in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cfg
      always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          cfg_mem[gi] <= `HCSC_CFG_RESET;
        end else if (reload_active) begin
          cfg_mem[gi] <= `HCSC_CFG_RESET;
        end else if (cfg_write_allowed && cfg_slot_hit(reg_addr_in, 3'(gi))) begin
          cfg_mem[gi] <= reg_wdata_in;
        end
      end
    end
  endgenerate
endmodule // hcsc_status_cmd

// ---- testbench/hcsc_monitor.sv ----
// assertions on the hub status/command bank ports
`timescale 1ns/1ps
module hcsc_monitor (
  // watched ports
  input wire logic clock_in, reset_n_in, mgmt_mode_enter_in, reg_write_in, reg_read_in,
  input wire logic [7:0] reg_addr_in, reg_rdata_out,
  input wire hcsc_pkg::hcsc_byte_t reg_wdata_in,
  input wire logic ganged_n_in, port_power_mgmt_n_in, power_enable_polarity_in,
  input wire logic [3:0] charge_enable_port_in, port_power_request_in, charge_enable_out, port_power_enable_out,
  input wire logic upstream_attach_allow_out, individual_power_out, reload_busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // accesses aimed at the status byte
  wire st = reg_addr_in == 8'hF8;
  wire stw = reg_write_in && st;
  rsvd_zero_a: assert property (reg_read_in && st |=> reg_rdata_out[7:2] == 6'h00)
    else $error("reserved bits");
  reload_start_a: assert property (stw && reg_wdata_in[1] |-> ##2 reload_busy_out)
    else $error("no reload");
  reload_len_a: assert property ($rose(reload_busy_out) |-> reload_busy_out[*7] ##1 !reload_busy_out)
    else $error("reload length");
  mode_hold_a: assert property ($rose(mgmt_mode_enter_in) |-> ##[2:6] !upstream_attach_allow_out)
    else $error("attach not held");
  clear_flag_a: assert property (stw && reg_wdata_in[0] && $stable(mgmt_mode_enter_in)
    |-> ##2 upstream_attach_allow_out) else $error("flag not cleared");
  indiv_pwr_a: assert property ((!ganged_n_in && !port_power_mgmt_n_in)[*4] |-> individual_power_out)
    else $error("power mode");
  charge_en_a: assert property ($stable(charge_enable_port_in)[*4] |-> charge_enable_out == charge_enable_port_in)
    else $error("charge enable");
  power_pol_a: assert property ((power_enable_polarity_in && $stable(port_power_request_in))[*4]
    |-> port_power_enable_out == port_power_request_in) else $error("power polarity");
endmodule // hcsc_monitor
bind hcsc_status_cmd hcsc_monitor mon (.*);

// ---- testbench/hcsc_host.sv ----
// management host model driving the register port
`timescale 1ns/1ps
module hcsc_host (
  input wire logic clock_in,
  output logic wr_out, rd_out,
  output logic [7:0] addr_out, wdata_out
);
  // one-cycle strobe, released bus shows inverted values
  task automatic access(input logic w, input logic [7:0] a, d);
    @(negedge clock_in);
    {wr_out, rd_out, addr_out, wdata_out} = {w, !w, a, d};
    @(negedge clock_in);
    {wr_out, rd_out, addr_out, wdata_out} = {2'b00, ~a, ~d};
  endtask
  // leave config mode so upstream may attach
  task automatic release_cfg(); access(1'b1, 8'hF8, 8'h01); endtask
  initial {wr_out, rd_out, addr_out, wdata_out} = 18'h00000;
endmodule // hcsc_host

// ---- testbench/hub_config_status_command_tb_top.sv ----
// self-checking bench for the hub status/command bank
`timescale 1ns/1ps
module hub_config_status_command_tb_top;
  logic clock_in = 1'b0, reset_n_in = 1'b0, mgmt_mode_enter_in = 1'b0, reg_write_in, reg_read_in;
  logic ganged_n_in = 1'b1, port_power_mgmt_n_in = 1'b1, power_enable_polarity_in = 1'b1;
  logic [3:0] charge_enable_port_in = 4'h0, port_power_request_in = 4'h0, charge_enable_out, port_power_enable_out;
  logic upstream_attach_allow_out, individual_power_out, reload_busy_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d;
  int fails = 0, n_checks = 0, seed = 32'hD736F566;
  hcsc_host host (.clock_in(clock_in), .wr_out(reg_write_in), .rd_out(reg_read_in), .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in));
  hcsc_status_cmd uut (.*);
  initial forever #20 clock_in = ~clock_in;
  // expected enables: requests pass straight when the polarity strap is high
  function automatic logic [7:0] exp_power(input logic pol, input logic [3:0] req);
    exp_power = {4'h0, pol ? req : ~req};
  endfunction
  task automatic check(input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    host.access(1'b0, a, 8'h00);
    @(negedge clock_in);
    check(reg_rdata_out, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // directed register sequence, then random straps
  initial begin
    repeat (20) @(negedge clock_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clock_in);
    rd_chk(8'hF8, 8'h00);
    check(upstream_attach_allow_out, 8'h01);
    mgmt_mode_enter_in = 1'b1;
    repeat (6) @(negedge clock_in);
    check(upstream_attach_allow_out, 8'h00);
    rd_chk(8'hF8, 8'h01);
    host.access(1'b1, 8'hF8, 8'hFC);
    rd_chk(8'hF8, 8'h01);
    host.release_cfg();
    @(negedge clock_in);
    check(upstream_attach_allow_out, 8'h01);
    d = (8'($random(seed)) & 8'h7F) | 8'h01;
    host.access(1'b1, 8'h03, d);
    rd_chk(8'h03, d);
    host.access(1'b1, 8'hF8, 8'h02);
    rd_chk(8'hF8, 8'h02);
    check(reload_busy_out, 8'h01);
    // config write lands in the done cycle, reload bit still set
    repeat (2) @(negedge clock_in);
    host.access(1'b1, 8'h03, ~d);
    rd_chk(8'hF8, 8'h00);
    check(reload_busy_out, 8'h00);
    rd_chk(8'h03, 8'h00);
    for (int i = 0; i < 10; i++) begin
      // first two rounds are fixed corners: both power straps low, each polarity
      {ganged_n_in, port_power_mgmt_n_in, power_enable_polarity_in, charge_enable_port_in,
        port_power_request_in} = (i == 0) ? 11'h1F5 : (i == 1) ? 11'h0AA : 11'($random(seed));
      repeat (5) @(negedge clock_in);
      check(individual_power_out, !ganged_n_in && !port_power_mgmt_n_in);
      check(charge_enable_out, charge_enable_port_in);
      check(port_power_enable_out, exp_power(power_enable_polarity_in, port_power_request_in));
    end
    finish_test();
  end
  // hang guard
  initial begin
    #20us;
    fails++;
    finish_test();
  end
endmodule // hub_config_status_command_tb_top
